// ===== common/cbm_params.svh
// Purpose: constants for the branch, move and stack execution unit
// Assumes: byte addressed memory holding 16-bit words at even addresses
// Notes:   definitions only, included by bare name
`ifndef CBM_PARAMS_SVH
`define CBM_PARAMS_SVH

// ==========================================================
// status word bit positions
`define CBM_SR_C       0
`define CBM_SR_Z       1
`define CBM_SR_N       2
`define CBM_SR_GIE     3
`define CBM_SR_CPU_OFF_BIT  4
`define CBM_SR_OSCILLATOR_OFF_BIT  5
`define CBM_SR_V       8
// stacked status word keeps program counter bits 19:16 here
`define CBM_SR_PCHI_LSB 12
`define CBM_SR_KEEP_MASK 16'h0fff

// ==========================================================
// register indices that this unit owns or filters
`define CBM_IDX_SP  4'h1
`define CBM_IDX_SR  4'h2
`define CBM_IDX_CG  4'h3

// ==========================================================
// reset values and arithmetic constants
`define CBM_SP_RST   20'h0_0000
`define CBM_SR_RST   16'h0000
`define CBM_STACK_STEP 20'h0_0002
`define CBM_BE_WORD  2'h3
`define CBM_BE_LOW   2'h1
`define CBM_HI_ZERO  8'h00
`define CBM_PCHI_ZERO 4'h0

`endif

// ===== common/cbm_pkg.sv
// Purpose: types shared by the execution unit, its checks, memory model and bench
// Assumes: nothing beyond the params header
// Notes:   types only; numbers live in cbm_params.svh
`default_nettype none
package cbm_pkg;

   // ==========================================================
   // instruction kinds handled here
   typedef enum logic [3:0] {
      KIND_NONE,
      KIND_JUMP_CARRY_CLEAR,
      KIND_JUMP_UNSIGNED_LOWER,
      KIND_JUMP_NONZERO,
      KIND_JUMP_NOT_EQUAL,
      KIND_MOVE_OP,
      KIND_NO_OPERATION,
      KIND_POP,
      KIND_PUSH,
      KIND_SUBROUTINE_RETURN,
      KIND_INTERRUPT_RETURN
   } cbm_kind_t;

   // ==========================================================
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_MEM,
      ST_INTERRUPT_RETURN_PC,
      ST_WRITEBACK
   } cbm_state_t;

   // ==========================================================
   // decoded command from the instruction decoder
   typedef struct packed {
      cbm_kind_t   kind;
      logic        byte_op;
      logic [9:0]  offset;
      logic [19:0] pc_next;
      logic [15:0] src_val;
      logic        dst_is_reg;
      logic [3:0]  dst_reg;
      logic [19:0] dst_addr;
   } cbm_cmd_t;

   // memory bus request
   typedef struct packed {
      logic        req;
      logic        we;
      logic [19:0] addr;
      logic [15:0] wdata;
      logic [1:0]  be;
   } cbm_mem_t;

   // register file write port
   typedef struct packed {
      logic        en;
      logic [3:0]  idx;
      logic [15:0] data;
   } cbm_regwr_t;

   // program counter load
   typedef struct packed {
      logic        en;
      logic [19:0] value;
   } cbm_pcwr_t;

   // status word update from the arithmetic unit
   typedef struct packed {
      logic        en;
      logic [15:0] value;
   } cbm_flagwr_t;

endpackage : cbm_pkg
`default_nettype wire

// ===== rtl/cbm_addr_unit.sv
// Purpose: jump target and stack pointer step arithmetic
// Assumes: offset is a signed word count, pc_next is a byte address
// Notes:   purely combinational, wraps modulo 1 MB
`timescale 1ns/100ps
`default_nettype none
`include "cbm_params.svh"
module cbm_addr_unit (
   input  wire logic [19:0] pc_next,
   input  wire logic [9:0]  offset,
   input  wire logic [19:0] sp,
   output var  logic [19:0] target,
   output var  logic [19:0] sp_inc,
   output var  logic [19:0] sp_dec
);

   // ==========================================================
   // relative target: offset doubled and sign extended to 20 bits
   // doubled signed offset
   // span -512..+511 words, wraps over full range
   always_comb begin
      target = pc_next + {{9{offset[9]}}, offset, 1'b0};
   end

   // ==========================================================
   // stack moves by one word whatever the operand size
   // step always two
   always_comb begin
      sp_inc = sp + `CBM_STACK_STEP;
      sp_dec = sp - `CBM_STACK_STEP;
   end

endmodule : cbm_addr_unit
`default_nettype wire

// ===== rtl/cbm_exec.sv
// Purpose: executes conditional jumps, move, no-op, stack and returns
// Assumes: memory answers each request with a one-cycle mem_ack
// Notes:   owns stack pointer and status word; other registers bar the
//          constant generator are written through the register write port
`timescale 1ns/100ps
`default_nettype none
`include "cbm_params.svh"
module cbm_exec (
   input  wire logic                clk,
   input  wire logic                nrst,
   input  wire logic                cmd_valid,
   input  wire cbm_pkg::cbm_cmd_t   cmd,
   output var  logic                cmd_ready,
   output var  logic                done,
   input  wire cbm_pkg::cbm_flagwr_t flag_wr,
   output var  cbm_pkg::cbm_mem_t   mem,
   input  wire logic                mem_ack,
   input  wire logic [15:0]         mem_rdata,
   output var  cbm_pkg::cbm_regwr_t reg_wr,
   output var  cbm_pkg::cbm_pcwr_t  pc_wr,
   output var  logic [19:0]         stack_pointer,
   output var  logic [15:0]         status_register
);

   // ==========================================================
   // complete state of the unit
   typedef struct packed {
      cbm_pkg::cbm_state_t st;
      cbm_pkg::cbm_cmd_t   cmd;
      logic [15:0]         temp;
      logic [19:0]         sp;
      logic [15:0]         sr;
      logic                ready;
      logic                done;
      cbm_pkg::cbm_mem_t   mem;
      cbm_pkg::cbm_regwr_t rw;
      cbm_pkg::cbm_pcwr_t  pcw;
   } cbm_regs_t;

   cbm_regs_t   s_r;
   cbm_regs_t   s_nxt;

   logic [19:0] add_target;
   logic [19:0] add_sp_inc;
   logic [19:0] add_sp_dec;
   logic [15:0] flags_now;

   // ==========================================================
   // address arithmetic
   cbm_addr_unit u_addr (
      .pc_next (cmd.pc_next),
      .offset  (cmd.offset),
      .sp      (s_r.sp),
      .target  (add_target),
      .sp_inc  (add_sp_inc),
      .sp_dec  (add_sp_dec)
   );

   // ==========================================================
   // helpers used on several paths

   // operand as written: byte form zero-fills the upper half
   function automatic logic [15:0] size_val(input logic byte_op,
                                            input logic [15:0] v);
      size_val = byte_op ? {`CBM_HI_ZERO, v[7:0]} : v;
   endfunction : size_val

   // byte lanes for a memory write
   function automatic logic [1:0] lanes(input logic byte_op);
      lanes = byte_op ? `CBM_BE_LOW : `CBM_BE_WORD;
   endfunction : lanes

   // memory request word
   function automatic cbm_pkg::cbm_mem_t mem_op(input logic we,
                                               input logic [19:0] a,
                                               input logic [15:0] d,
                                               input logic [1:0] be);
      mem_op.req   = 1'b1;
      mem_op.we    = we;
      mem_op.addr  = a;
      mem_op.wdata = d;
      mem_op.be    = be;
   endfunction : mem_op

   // ==========================================================
   // flags seen by a jump: an update landing this cycle is bypassed
   // so a jump right after a compare is not one instruction late
   // bypass fresh flags
   always_comb begin
      flags_now = flag_wr.en ? flag_wr.value : s_r.sr;
   end

   // ==========================================================
   // next-state logic
   always_comb begin
      logic        take;
      logic [15:0] wval;
      take  = 1'b0;
      wval  = 16'h0000;
      s_nxt = s_r;
      s_nxt.done   = 1'b0;
      s_nxt.rw.en  = 1'b0;
      s_nxt.pcw.en = 1'b0;
      // other instructions update flags through this port
      if (flag_wr.en) begin
         s_nxt.sr = flag_wr.value;
      end
      unique case (s_r.st)
         cbm_pkg::ST_IDLE: begin
            if (cmd_valid && s_r.ready) begin
               s_nxt.cmd = cmd;
               unique case (cmd.kind)
                  cbm_pkg::KIND_JUMP_CARRY_CLEAR,
                  cbm_pkg::KIND_JUMP_UNSIGNED_LOWER: begin
                     take = ~flags_now[`CBM_SR_C];
                  end
                  cbm_pkg::KIND_JUMP_NONZERO,
                  cbm_pkg::KIND_JUMP_NOT_EQUAL: begin
                     take = ~flags_now[`CBM_SR_Z];
                  end
                  default: begin
                     take = 1'b0;
                  end
               endcase
               unique case (cmd.kind)
                  cbm_pkg::KIND_JUMP_CARRY_CLEAR,
                  cbm_pkg::KIND_JUMP_UNSIGNED_LOWER,
                  cbm_pkg::KIND_JUMP_NONZERO,
                  cbm_pkg::KIND_JUMP_NOT_EQUAL: begin
                     s_nxt.pcw.en    = 1'b1;
                     s_nxt.pcw.value = take ? add_target : cmd.pc_next;
                     s_nxt.done      = 1'b1;
                  end
                  cbm_pkg::KIND_MOVE_OP: begin
                     wval = size_val(cmd.byte_op, cmd.src_val);
                     if (cmd.dst_is_reg) begin
                        s_nxt.done = 1'b1;
                        if (cmd.dst_reg == `CBM_IDX_SP) begin
                           s_nxt.sp = {`CBM_PCHI_ZERO, wval};
                        end else if (cmd.dst_reg == `CBM_IDX_SR) begin
                           s_nxt.sr = wval;
                        end else if (cmd.dst_reg != `CBM_IDX_CG) begin
                           s_nxt.rw.en   = 1'b1;
                           s_nxt.rw.idx  = cmd.dst_reg;
                           s_nxt.rw.data = wval;
                        end
                     end else begin
                        s_nxt.ready = 1'b0;
                        s_nxt.st    = cbm_pkg::ST_MEM;
                        s_nxt.mem   = mem_op(1'b1, cmd.dst_addr, wval,
                                             lanes(cmd.byte_op));
                     end
                  end
                  cbm_pkg::KIND_PUSH: begin
                     s_nxt.sp    = add_sp_dec;
                     s_nxt.ready = 1'b0;
                     s_nxt.st    = cbm_pkg::ST_MEM;
                     s_nxt.mem   = mem_op(1'b1, add_sp_dec,
                                          size_val(cmd.byte_op, cmd.src_val),
                                          lanes(cmd.byte_op));
                  end
                  cbm_pkg::KIND_POP,
                  cbm_pkg::KIND_SUBROUTINE_RETURN,
                  cbm_pkg::KIND_INTERRUPT_RETURN: begin
                     s_nxt.ready = 1'b0;
                     s_nxt.st    = cbm_pkg::ST_MEM;
                     s_nxt.mem   = mem_op(1'b0, s_r.sp, 16'h0000,
                                          `CBM_BE_WORD);
                  end
                  default: begin
                     s_nxt.done = 1'b1;
                  end
               endcase
            end
         end
         cbm_pkg::ST_MEM: begin
            if (mem_ack) begin
               s_nxt.mem.req = 1'b0;
               unique case (s_r.cmd.kind)
                  cbm_pkg::KIND_POP: begin
                     s_nxt.temp = mem_rdata;
                     s_nxt.sp   = add_sp_inc;
                     s_nxt.st   = cbm_pkg::ST_WRITEBACK;
                  end
                  cbm_pkg::KIND_SUBROUTINE_RETURN: begin
                     s_nxt.pcw.en    = 1'b1;
                     s_nxt.pcw.value = {`CBM_PCHI_ZERO, mem_rdata};
                     s_nxt.sp        = add_sp_inc;
                     s_nxt.done      = 1'b1;
                     s_nxt.ready     = 1'b1;
                     s_nxt.st        = cbm_pkg::ST_IDLE;
                  end
                  cbm_pkg::KIND_INTERRUPT_RETURN: begin
                     s_nxt.sr   = mem_rdata & `CBM_SR_KEEP_MASK;
                     s_nxt.temp = mem_rdata;
                     s_nxt.sp   = add_sp_inc;
                     s_nxt.st   = cbm_pkg::ST_INTERRUPT_RETURN_PC;
                     s_nxt.mem  = mem_op(1'b0, add_sp_inc, 16'h0000,
                                         `CBM_BE_WORD);
                  end
                  default: begin
                     // writes (move, push, pop to memory) finish here
                     s_nxt.done  = 1'b1;
                     s_nxt.ready = 1'b1;
                     s_nxt.st    = cbm_pkg::ST_IDLE;
                  end
               endcase
            end
         end
         cbm_pkg::ST_INTERRUPT_RETURN_PC: begin
            if (mem_ack) begin
               // counter low word, high bits from status word
               s_nxt.mem.req   = 1'b0;
               s_nxt.pcw.en    = 1'b1;
               s_nxt.pcw.value = {s_r.temp[15:`CBM_SR_PCHI_LSB], mem_rdata};
               s_nxt.sp        = add_sp_inc;
               s_nxt.done      = 1'b1;
               s_nxt.ready     = 1'b1;
               s_nxt.st        = cbm_pkg::ST_IDLE;
            end
         end
         cbm_pkg::ST_WRITEBACK: begin
            wval = size_val(s_r.cmd.byte_op, s_r.temp);
            if (s_r.cmd.dst_is_reg) begin
               s_nxt.done  = 1'b1;
               s_nxt.ready = 1'b1;
               s_nxt.st    = cbm_pkg::ST_IDLE;
               if (s_r.cmd.dst_reg == `CBM_IDX_SP) begin
                  s_nxt.sp = {`CBM_PCHI_ZERO, wval};
               end else if (s_r.cmd.dst_reg == `CBM_IDX_SR) begin
                  s_nxt.sr = wval;
               end else if (s_r.cmd.dst_reg != `CBM_IDX_CG) begin
                  s_nxt.rw.en   = 1'b1;
                  s_nxt.rw.idx  = s_r.cmd.dst_reg;
                  s_nxt.rw.data = wval;
               end
            end else begin
               // a memory destination reuses the move write path
               s_nxt.cmd.kind = cbm_pkg::KIND_MOVE_OP;
               s_nxt.st       = cbm_pkg::ST_MEM;
               s_nxt.mem      = mem_op(1'b1, s_r.cmd.dst_addr, wval,
                                       lanes(s_r.cmd.byte_op));
            end
         end
         default: begin
            // an illegal code returns to rest without side effects
            s_nxt.st    = cbm_pkg::ST_IDLE;
            s_nxt.ready = 1'b1;
            s_nxt.mem   = '0;
         end
      endcase
   end

   // ==========================================================
   // state register
   // mode bits only change through interrupt return, flag_wr, or a move or pop to the status word
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_r       <= '0;
         s_r.st    <= cbm_pkg::ST_IDLE;
         s_r.sp    <= `CBM_SP_RST;
         s_r.sr    <= `CBM_SR_RST;
         s_r.ready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // outputs straight from the state register
   always_comb begin
      cmd_ready       = s_r.ready;
      done            = s_r.done;
      mem             = s_r.mem;
      reg_wr          = s_r.rw;
      pc_wr           = s_r.pcw;
      stack_pointer   = s_r.sp;
      status_register = s_r.sr;
   end

endmodule : cbm_exec
`default_nettype wire

// ===== dv/cbm_exec_properties.sv
// Purpose: port level checks on the branch, move and stack unit
// Assumes: one clock, asynchronous active low reset
// Notes:   bound to every cbm_exec instance
`timescale 1ns/100ps
`default_nettype none
module cbm_exec_properties (
   input wire logic                 clk,
   input wire logic                 nrst,
   input wire logic                 cmd_valid,
   input wire cbm_pkg::cbm_cmd_t    cmd,
   input wire logic                 cmd_ready,
   input wire logic                 done,
   input wire cbm_pkg::cbm_flagwr_t flag_wr,
   input wire cbm_pkg::cbm_mem_t    mem,
   input wire logic                 mem_ack,
   input wire logic [15:0]          mem_rdata,
   input wire cbm_pkg::cbm_regwr_t  reg_wr,
   input wire cbm_pkg::cbm_pcwr_t   pc_wr,
   input wire logic [19:0]          stack_pointer,
   input wire logic [15:0]          status_register
);
   // ==========================================
   // helper terms
   logic               take;
   logic               cc;
   logic               nz;
   logic [15:0]        fl;
   logic [19:0]        tgt;
   cbm_pkg::cbm_kind_t kind_r;
   logic               byte_r;
   logic               second_r;
   logic [3:0]         hi_r;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // a flag update in the take cycle is what the jump must see
   assign take = cmd_valid && cmd_ready;
   assign fl   = flag_wr.en ? flag_wr.value : status_register;
   assign cc   = cmd.kind inside {cbm_pkg::KIND_JUMP_CARRY_CLEAR,
      cbm_pkg::KIND_JUMP_UNSIGNED_LOWER};
   assign nz   = cmd.kind inside {cbm_pkg::KIND_JUMP_NONZERO, cbm_pkg::KIND_JUMP_NOT_EQUAL};
   assign tgt  = cmd.pc_next + {{9{cmd.offset[9]}}, cmd.offset, 1'b0};
   // command in flight; first answer only, so the second read cannot clobber it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         kind_r   <= cbm_pkg::KIND_NONE;
         byte_r   <= 1'b0;
         second_r <= 1'b0;
         hi_r     <= 4'h0;
      end else if (take) begin
         kind_r   <= cmd.kind;
         byte_r   <= cmd.byte_op;
         second_r <= 1'b0;
      end else if (mem_ack && !second_r) begin
         second_r <= 1'b1;
         hi_r     <= mem_rdata[15:12];
      end
   end
   property p_jump_carry;
      take && cc && !fl[0] |=> pc_wr.en && pc_wr.value == $past(tgt);
   endproperty
   a_jump_carry: assert property (p_jump_carry) else $error("carry jump target");
   property p_jump_zero;
      take && nz && !fl[1] |=> pc_wr.en && pc_wr.value == $past(tgt);
   endproperty
   a_jump_zero: assert property (p_jump_zero) else $error("zero jump target");
   property p_jump_seq;
      take && (cc && fl[0] || nz && fl[1]) |=> pc_wr.en && pc_wr.value == $past(cmd.pc_next);
   endproperty
   a_jump_seq: assert property (p_jump_seq) else $error("jump fall through");
   property p_flags_kept;
      take && !flag_wr.en && !(cmd.dst_is_reg && cmd.dst_reg == 4'h2) && (cc || nz ||
      cmd.kind inside {cbm_pkg::KIND_MOVE_OP, cbm_pkg::KIND_PUSH}) |=> $stable(status_register);
   endproperty
   a_flags_kept: assert property (p_flags_kept) else $error("status word changed");
   property p_nop_idle;
      take && !flag_wr.en && cmd.kind == cbm_pkg::KIND_NO_OPERATION |=> !reg_wr.en && !mem.req
      && $stable(stack_pointer) && $stable(status_register);
   endproperty
   a_nop_idle: assert property (p_nop_idle) else $error("no-op changed state");
   property p_push;
      take && cmd.kind == cbm_pkg::KIND_PUSH |=> stack_pointer == $past(stack_pointer) - 20'h0_0002
      && mem.req && mem.we && mem.addr == stack_pointer && mem.be == ($past(cmd.byte_op) ? 2'h1 : 2'h3);
   endproperty
   a_push: assert property (p_push) else $error("push address or lanes");
   // every stack read steps by two
   property p_read_step;
      mem_ack && mem.req && !mem.we |=> stack_pointer == $past(stack_pointer) + 20'h0_0002;
   endproperty
   a_read_step: assert property (p_read_step) else $error("stack step after read");
   property p_pop_byte;
      reg_wr.en && kind_r == cbm_pkg::KIND_POP && byte_r |-> reg_wr.data[15:8] == 8'h00;
   endproperty
   a_pop_byte: assert property (p_pop_byte) else $error("byte pop high byte");
   property p_ret_pc;
      kind_r == cbm_pkg::KIND_SUBROUTINE_RETURN && mem_ack |=> pc_wr.en && done
      && pc_wr.value == {4'h0, $past(mem_rdata)};
   endproperty
   a_ret_pc: assert property (p_ret_pc) else $error("return address");
   property p_interrupt_return_sr;
      kind_r == cbm_pkg::KIND_INTERRUPT_RETURN && mem_ack && !second_r
      |=> status_register == ($past(mem_rdata) & 16'h0fff);
   endproperty
   a_interrupt_return_sr: assert property (p_interrupt_return_sr) else $error("restored status");
   property p_interrupt_return_pc;
      kind_r == cbm_pkg::KIND_INTERRUPT_RETURN && mem_ack && second_r
      |=> pc_wr.en && done && pc_wr.value == {hi_r, $past(mem_rdata)};
   endproperty
   a_interrupt_return_pc: assert property (p_interrupt_return_pc) else $error("interrupt return address");
endmodule : cbm_exec_properties

bind cbm_exec cbm_exec_properties cbm_exec_properties_inst (.clk(clk), .nrst(nrst),
   .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .done(done), .flag_wr(flag_wr),
   .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .reg_wr(reg_wr), .pc_wr(pc_wr),
   .stack_pointer(stack_pointer), .status_register(status_register));
`default_nettype wire

// ===== dv/cbm_mem_model.sv
// Purpose: word memory answering the unit's bus requests
// Assumes: only address bits 9:1 matter, higher ones alias
// Notes:   read data toggles whenever no answer is given
`timescale 1ns/100ps
`default_nettype none
module cbm_mem_model (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire cbm_pkg::cbm_mem_t mem,
   input  wire logic [1:0]        wait_cycles,
   output var  logic              mem_ack,
   output var  logic [15:0]       mem_rdata
);
   logic [15:0] ram [512];
   logic [1:0]  cnt;
   // ==========================================
   // one-cycle answer after a variable wait; stale data is never held
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mem_ack   <= 1'b0;
         cnt       <= 2'h0;
         mem_rdata <= 16'h0000;
      end else if (mem.req && !mem_ack && cnt >= wait_cycles) begin
         mem_ack   <= 1'b1;
         cnt       <= 2'h0;
         mem_rdata <= ram[mem.addr[9:1]];
         if (mem.we && mem.be[0]) ram[mem.addr[9:1]][7:0] <= mem.wdata[7:0];
         if (mem.we && mem.be[1]) ram[mem.addr[9:1]][15:8] <= mem.wdata[15:8];
      end else begin
         mem_ack   <= 1'b0;
         cnt       <= cnt + {1'b0, mem.req};
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule : cbm_mem_model
`default_nettype wire

// ===== dv/test_cpu_branch_move_stack_ops.sv
// Purpose: self-checking bench for the branch, move and stack unit
// Assumes: memory answers after zero to three wait cycles
// Notes:   inputs change on the falling edge only
`timescale 1ns/100ps
`default_nettype none
module test_cpu_branch_move_stack_ops;
   logic                 clk;
   logic                 nrst;
   logic                 cmd_valid;
   cbm_pkg::cbm_cmd_t    cmd;
   logic                 cmd_ready;
   logic                 done;
   cbm_pkg::cbm_flagwr_t flag_wr;
   cbm_pkg::cbm_flagwr_t f;
   cbm_pkg::cbm_mem_t    mem;
   logic                 mem_ack;
   logic [15:0]          mem_rdata;
   cbm_pkg::cbm_regwr_t  reg_wr;
   cbm_pkg::cbm_pcwr_t   pc_wr;
   logic [19:0]          stack_pointer;
   logic [15:0]          status_register;
   logic [1:0]           wait_cycles;
   logic [19:0]          got_pc;
   logic [15:0]          got_reg;
   logic                 got_wr;
   logic [15:0]          fl;
   logic [15:0]          d;
   logic [15:0]          pre;
   logic [15:0]          w0;
   logic [15:0]          w1;
   logic [19:0]          pc;
   logic [19:0]          exp_sp;
   logic [19:0]          sp2;
   logic [15:0]          exp_sr;
   logic [9:0]           off;
   logic                 b;
   int                   failures;
   int                   checks;
   cbm_pkg::cbm_kind_t   kinds [4] = '{cbm_pkg::KIND_JUMP_CARRY_CLEAR,
      cbm_pkg::KIND_JUMP_UNSIGNED_LOWER, cbm_pkg::KIND_JUMP_NONZERO, cbm_pkg::KIND_JUMP_NOT_EQUAL};

   cbm_exec cbm_exec_inst (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .done(done), .flag_wr(flag_wr), .mem(mem), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .reg_wr(reg_wr), .pc_wr(pc_wr), .stack_pointer(stack_pointer),
      .status_register(status_register));
   cbm_mem_model cbm_mem_model_inst (.clk(clk), .nrst(nrst), .mem(mem),
      .wait_cycles(wait_cycles), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   // ==========================================
   // clock, and a memory latency that changes every cycle
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(negedge clk) wait_cycles <= 2'($urandom_range(0, 3));

   // ==========================================
   // compare, verdict and one command with its answer
   task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] seen);
      checks++;
      if (seen !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, seen);
         failures++;
      end
   endtask : chk
   task automatic test_done();
      if (failures == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done
   task automatic run(input cbm_pkg::cbm_cmd_t c, input cbm_pkg::cbm_flagwr_t fw);
      int n;
      n = 0;
      got_wr = 1'b0;
      @(negedge clk);
      while (cmd_ready !== 1'b1) @(negedge clk);
      cmd = c;
      flag_wr = fw;
      cmd_valid = 1'b1;
      do begin
         @(negedge clk);
         cmd_valid = 1'b0;
         flag_wr = '0;
         if (pc_wr.en === 1'b1) got_pc = pc_wr.value;
         if (reg_wr.en === 1'b1) got_wr = 1'b1;
         if (reg_wr.en === 1'b1) got_reg = reg_wr.data;
         n++;
      end while (done !== 1'b1 && n < 40);
      chk("done", 20'h0_0001, 20'(n < 40));
   endtask : run
   function automatic logic [19:0] jt(input logic [19:0] p, input logic [9:0] o);
      return p + {{9{o[9]}}, o, 1'b0};
   endfunction : jt

   // ==========================================
   // hang guard, far beyond the cycles needed
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      test_done();
   end

   initial begin
      void'($urandom(32'hdd62_6043));
      {nrst, cmd_valid, cmd, flag_wr, wait_cycles, failures, checks} = '0;
      {got_pc, got_reg, exp_sp, exp_sr} = '0;
      repeat (20) @(posedge clk);
      @(negedge clk) nrst = 1'b1;
      chk("sp", exp_sp, stack_pointer);
      // every jump kind, edge offsets wrap the full range, flags same cycle
      for (int i = 0; i < 60; i++) begin
         off = (i < 2) ? {i[0], {9{~i[0]}}} : 10'($urandom);
         pc = (i < 2) ? 20'h0_0004 : 20'($urandom);
         f = '{1'($urandom), 16'($urandom)};
         fl = f.en ? f.value : exp_sr;
         run('{kinds[i % 4], 1'b0, off, pc, 16'h0000, 1'b0, 4'h0, 20'h0_0000}, f);
         chk("jump", ((i % 4 < 2) ? fl[0] : fl[1]) ? pc : jt(pc, off), got_pc);
         exp_sr = fl;
         chk("sr", 20'(exp_sr), 20'(status_register));
      end
      // moves to registers and memory, word and byte
      for (int i = 0; i < 16; i++) begin
         d = 16'($urandom);
         b = i[0];
         pre = 16'($urandom);
         cbm_mem_model_inst.ram[9'h040 + i] = pre;
         run('{cbm_pkg::KIND_MOVE_OP, b, 10'h000, 20'h0_0000, d, i[1], 4'(i % 8 + 4),
            20'h0_0080 + 20'(2 * i)}, '0);
         if (i[1]) chk("move reg", 20'(b ? {8'h00, d[7:0]} : d), 20'(got_reg));
         else chk("move mem", 20'(b ? {pre[15:8], d[7:0]} : d),
            20'(cbm_mem_model_inst.ram[9'h040 + i]));
         chk("sr", 20'(exp_sr), 20'(status_register));
      end
      run('{cbm_pkg::KIND_NO_OPERATION, 1'b0, 10'h000, 20'h0_0000, 16'h0000,
         1'b1, 4'h3, 20'h0_0000}, '0);
      chk("no-op write", 20'h0_0000, 20'(got_wr));
      // push then pop back, byte and word alternating
      for (int i = 0; i < 8; i++) begin
         d = 16'($urandom);
         b = i[0];
         exp_sp = exp_sp - 20'h0_0002;
         pre = 16'($urandom);
         cbm_mem_model_inst.ram[exp_sp[9:1]] = pre;
         run('{cbm_pkg::KIND_PUSH, b, 10'h000, 20'h0_0000, d, 1'b0, 4'h0, 20'h0_0000}, '0);
         chk("push sp", exp_sp, stack_pointer);
         w0 = b ? {pre[15:8], d[7:0]} : d;
         chk("push data", 20'(w0), 20'(cbm_mem_model_inst.ram[exp_sp[9:1]]));
         run('{cbm_pkg::KIND_POP, b, 10'h000, 20'h0_0000, 16'h0000, b, 4'h5, 20'h0_0040}, '0);
         exp_sp = exp_sp + 20'h0_0002;
         chk("pop sp", exp_sp, stack_pointer);
         if (b) chk("pop reg", 20'({8'h00, w0[7:0]}), 20'(got_reg));
         else chk("pop mem", 20'(w0), 20'(cbm_mem_model_inst.ram[9'h020]));
      end
      for (int i = 0; i < 8; i++) begin
         w0 = 16'($urandom);
         w1 = 16'($urandom);
         sp2 = exp_sp + 20'h0_0002;
         cbm_mem_model_inst.ram[exp_sp[9:1]] = w0;
         cbm_mem_model_inst.ram[sp2[9:1]] = w1;
         run('{i[0] ? cbm_pkg::KIND_INTERRUPT_RETURN : cbm_pkg::KIND_SUBROUTINE_RETURN, 1'b0,
            10'h000, 20'h0_0000, 16'h0000, 1'b0, 4'h0, 20'h0_0000}, '0);
         exp_sp = exp_sp + (i[0] ? 20'h0_0004 : 20'h0_0002);
         if (i[0]) exp_sr = w0 & 16'h0fff;
         chk("return pc", i[0] ? {w0[15:12], w1} : {4'h0, w0}, got_pc);
         chk("return sp", exp_sp, stack_pointer);
         chk("return sr", 20'(exp_sr), 20'(status_register));
      end
      test_done();
   end
endmodule : test_cpu_branch_move_stack_ops
`default_nettype wire
